// ### design/mve_value_encoder.sv
/*
 * Holding-register value encoder: measured values as floats with
 * status codes, date/time, indications, controllable indications and
 * signed energy counters with their quality flags.
 * Assumes all inputs come from logic on sys_clk and that the protocol
 * engine hands over one register access at a time.
 */
`timescale 1ns/1ns
`include "mve_regs.svh"

// Contract
// - lowest register holds most significant byte
// - measured values as two-register IEEE floats
// - float exponent zero, 255, normal meaning
// - overflow 7F800000H, invalid 7F800001H
// - not calculated gives 7F800002H
// - time register one: milliseconds 0..59999
// - hours/minutes then month/day byte layout
// - status/year register, DST 10H, fault 20H
// - eight two-bit indications, indication 1 lowest
// - trust set when from invalid value
// - always-valid indications report trust zero
// - low voltage makes frequency and limits invalid
// - command register readable as indication pairs
// - ON/OFF pairs execute, equal pairs ignored
// - counters are signed 32-bit pulse counts
// - counter range plus/minus 2147483647
// - wrap flag set past 31 bits, cleared by reset
// - untrusted flag cleared one minute after start
// - quality pairs: wrap upper, untrusted lower
// - one shared energy-per-pulse float published
// - 60000 pulses per hour at rated
// - new time applied after all four writes
// - writes to read-only registers give code 03
module mve_value_encoder #(
    parameter longint unsigned MINUTE_CYCLES = `MVE_MINUTE_CYCLES,
    parameter longint unsigned PULSE_CYCLES  = `MVE_PULSE_CYCLES
) (
    input  wire logic                 sys_clk,     // system clock
    input  wire logic                 rstn,        // sync reset
    input  wire mve_pkg::mve_req_t    busReq,      // register access
    output mve_pkg::mve_resp_t        busResp,     // access answer
    input  wire logic [3:0][31:0]     measRaw,     // freq,volt,curr,pwr
    input  wire logic [3:0]           measNotCalc, // not calculated
    input  wire logic [3:0]           measInvalid, // invalid, other cause
    input  wire logic [15:0]          voltMag,     // voltage, rated 1000
    input  wire logic [15:0]          currMag,     // current, rated 1000
    input  wire logic [31:0]          pulseFactor, // energy per pulse
    input  wire mve_pkg::mve_time_t   rtcNow,      // running clock
    output mve_pkg::mve_time_t        timeSet,     // time to load
    output logic                      timeSetStb,  // load pulse
    input  wire logic                 devReady,    // device healthy
    input  wire logic [7:0]           indValue,    // indication ON
    input  wire logic [7:0]           indTrust,    // from invalid value
    input  wire logic [7:0]           indFreqDep,  // built on frequency
    input  wire logic [3:0][17:0]     cntPower,    // signed power each
    output logic [7:0]                cmdState,    // commanded states
    output logic [7:0]                cmdOnPulse,  // ON executed
    output logic [7:0]                cmdOffPulse  // OFF executed
);
    import mve_pkg::*;

    localparam int NCNT = 4;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // status codes replace the value; not-calculated outranks invalid,
    // invalid outranks overflow since an invalid value has no size
    function automatic logic [31:0] encodeMeas(
        input logic [31:0] raw,
        input logic        ovf,
        input logic        inv,
        input logic        nc
    );
        if (nc)
            encodeMeas = `MVE_F_NOTCALC;
        else if (inv)
            encodeMeas = `MVE_F_INVALID;
        else if (ovf)
            encodeMeas = `MVE_F_OVERFLOW;
        else
            encodeMeas = raw;
    endfunction : encodeMeas

    // big-endian split: lower register carries the upper half
    function automatic logic [15:0] wordOf(
        input logic [31:0] val,
        input logic        second
    );
        wordOf = second ? val[15:0] : val[31:16];
    endfunction : wordOf

    // ----------------------------------------------------------------
    // measured values
    // ----------------------------------------------------------------
    logic        voltLow;
    logic [3:0]  measOvf;
    logic [3:0]  measInv;
    logic [3:0][31:0] measWord;

    assign voltLow = voltMag < `MVE_VOLT_LOW;
    assign measOvf = {1'b0, currMag > `MVE_CURR_OVF,
                      voltMag > `MVE_VOLT_OVF, 1'b0};
    // frequency cannot be measured on too small a voltage
    assign measInv = measInvalid | {3'b000, voltLow};

    genvar gm;
    generate
        for (gm = 0; gm < 4; gm++)
        begin : g_meas
            assign measWord[gm] = encodeMeas(measRaw[gm], measOvf[gm],
                                             measInv[gm],
                                             measNotCalc[gm]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // read-only indications
    // ----------------------------------------------------------------
    logic [15:0] devIndWord;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ind
            if (gi == 0)
            begin : g_ready
                // device healthy can never be invalid
                assign devIndWord[1:0] = {1'b0, devReady};
            end
            else
            begin : g_plain
                assign devIndWord[2*gi]   = indValue[gi];
                assign devIndWord[2*gi+1] = indTrust[gi] |
                    (indFreqDep[gi] & voltLow);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [15:0] addr;
    logic        isWrite;
    logic        hitTime;
    logic [1:0]  timeIdx;
    logic        hitMeas;
    logic [2:0]  measIdx;
    logic        hitCnt;
    logic [2:0]  cntIdx;
    logic        hitFactor;
    logic        hitDevInd;
    logic        hitCmd;
    logic        hitQual;
    logic        hitAny;
    logic        hitWritable;
    logic [15:0] measOff;
    logic [15:0] cntOff;
    logic [15:0] timeOff;
    logic [15:0] factorOff;

    assign addr      = busReq.addr;
    assign isWrite   = busReq.write;
    assign timeOff   = addr - `MVE_REG_TIME_MS;
    assign measOff   = addr - `MVE_REG_MEAS_BASE;
    assign cntOff    = addr - `MVE_REG_CNT_BASE;
    assign factorOff = addr - `MVE_REG_PULSE_FACTOR;
    assign hitTime   = timeOff < 16'h0004;
    assign timeIdx   = timeOff[1:0];
    assign hitMeas   = measOff < 16'h0008;
    assign measIdx   = measOff[2:0];
    assign hitCnt    = cntOff < 16'h0008;
    assign cntIdx    = cntOff[2:0];
    assign hitFactor = factorOff < 16'h0002;
    assign hitDevInd = addr == `MVE_REG_DEV_IND;
    assign hitCmd    = addr == `MVE_REG_CMD_IND;
    assign hitQual   = addr == `MVE_REG_CNT_QUAL;
    assign hitAny    = hitTime | hitMeas | hitCnt | hitFactor |
                       hitDevInd | hitCmd | hitQual;
    assign hitWritable = hitTime | hitCmd;

    // ----------------------------------------------------------------
    // energy counters and quality flags
    // ----------------------------------------------------------------
    logic signed [31:0] cntValue [NCNT];
    logic [NCNT-1:0]    cntWrap;
    logic [NCNT-1:0]    cntUntrusted;
    logic               cntClear;
    logic [31:0]        minuteCnt;
    logic               minuteDone;
    logic [15:0]        qualWord;

    genvar gc;
    generate
        for (gc = 0; gc < NCNT; gc++)
        begin : g_cnt
            mve_energy_counter #(
                .PULSE_CYCLES (PULSE_CYCLES)
            ) u_cnt (
                .sys_clk (sys_clk),
                .rstn    (rstn),
                .power   (cntPower[gc]),
                .clear   (cntClear),
                .count   (cntValue[gc]),
                .wrap    (cntWrap[gc])
            );
            assign qualWord[2*gc]   = cntUntrusted[gc];
            assign qualWord[2*gc+1] = cntWrap[gc];
        end
    endgenerate
    assign qualWord[15:2*NCNT] = '0;

    // one minute of settling after start or counter reset
    assign minuteDone = minuteCnt == 32'(MINUTE_CYCLES - 1);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || cntClear)
            minuteCnt <= 32'h0;
        else if (!minuteDone)
            minuteCnt <= minuteCnt + 32'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || cntClear)
            cntUntrusted <= '1;
        else if (minuteDone)
            cntUntrusted <= '0;
    end

    // ----------------------------------------------------------------
    // controllable indications: ON in upper bit, OFF in lower
    // ----------------------------------------------------------------
    logic        cmdWrite;
    logic [7:0]  wrOn;
    logic [7:0]  wrOff;
    logic [15:0] cmdWord;

    assign cmdWrite = busReq.valid & isWrite & hitCmd;

    genvar gk;
    generate
        for (gk = 0; gk < 8; gk++)
        begin : g_cmd
            // equal bits in a pair leave that command alone
            assign wrOn[gk]  = cmdWrite & busReq.wdata[2*gk+1] &
                               ~busReq.wdata[2*gk];
            assign wrOff[gk] = cmdWrite & ~busReq.wdata[2*gk+1] &
                               busReq.wdata[2*gk];
            // commanded states are always valid
            assign cmdWord[2*gk+1:2*gk] = {1'b0, cmdState[gk]};
        end
    endgenerate
    assign cntClear = cmdOnPulse[`MVE_CMD_CNT_RESET];

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            cmdState    <= 8'h00;
            cmdOnPulse  <= 8'h00;
            cmdOffPulse <= 8'h00;
        end
        else
        begin
            cmdState    <= (cmdState | wrOn) & ~wrOff;
            cmdOnPulse  <= wrOn;
            cmdOffPulse <= wrOff;
        end
    end

    // ----------------------------------------------------------------
    // date and time: staged until all four registers arrive
    // ----------------------------------------------------------------
    logic [3:0][15:0] timeStage;
    logic [3:0]       timeSeen;
    logic             timeWrite;
    logic [3:0]       next_timeSeen;
    logic [3:0][15:0] next_timeStage;
    logic             timeCommit;
    logic             timeBad;
    mve_time_t        stagedTime;
    logic [15:0]      rtcWord [4];

    assign timeWrite = busReq.valid & isWrite & hitTime;

    always_comb
    begin
        next_timeStage = timeStage;
        next_timeSeen  = timeSeen;
        if (timeWrite)
        begin
            next_timeStage[timeIdx] = busReq.wdata;
            next_timeSeen[timeIdx]  = 1'b1;
        end
    end

    // date first then time, or all four at once, both end complete
    assign timeCommit = timeWrite & (&next_timeSeen);

    assign stagedTime.ms     = next_timeStage[0];
    assign stagedTime.hour   = next_timeStage[1][15:8];
    assign stagedTime.minute = next_timeStage[1][7:0];
    assign stagedTime.month  = next_timeStage[2][15:8];
    assign stagedTime.day    = next_timeStage[2][7:0];
    assign stagedTime.year   = next_timeStage[3][7:0];
    assign stagedTime.dst    = |(next_timeStage[3][15:8] & `MVE_TS_DST);
    assign stagedTime.fail   = |(next_timeStage[3][15:8] & `MVE_TS_FAIL);

    assign timeBad = stagedTime.ms > `MVE_MS_MAX ||
                     stagedTime.hour > `MVE_HOUR_MAX ||
                     stagedTime.minute > `MVE_MIN_MAX ||
                     stagedTime.month == 8'h00 ||
                     stagedTime.month > `MVE_MONTH_MAX ||
                     stagedTime.day == 8'h00 ||
                     stagedTime.day > `MVE_DAY_MAX;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            timeStage  <= '0;
            timeSeen   <= 4'h0;
            timeSet    <= '0;
            timeSetStb <= 1'b0;
        end
        else
        begin
            timeStage  <= next_timeStage;
            timeSeen   <= timeCommit ? 4'h0 : next_timeSeen;
            timeSetStb <= timeCommit & ~timeBad;
            if (timeCommit && !timeBad)
                timeSet <= stagedTime;
        end
    end

    assign rtcWord[0] = rtcNow.ms;
    assign rtcWord[1] = {rtcNow.hour, rtcNow.minute};
    assign rtcWord[2] = {rtcNow.month, rtcNow.day};
    assign rtcWord[3] = {(rtcNow.dst  ? `MVE_TS_DST  : 8'h00) |
                         (rtcNow.fail ? `MVE_TS_FAIL : 8'h00),
                         rtcNow.year};

    // ----------------------------------------------------------------
    // read selection and answer
    // ----------------------------------------------------------------
    logic [15:0] readWord;
    logic [7:0]  excCode;

    always_comb
    begin
        readWord = 16'h0000;
        if (hitTime)
            readWord = rtcWord[timeIdx];
        else if (hitMeas)
            readWord = wordOf(measWord[measIdx[2:1]], measIdx[0]);
        else if (hitCnt)
            readWord = wordOf(cntValue[cntIdx[2:1]], cntIdx[0]);
        else if (hitFactor)
            readWord = wordOf(pulseFactor, factorOff[0]);
        else if (hitDevInd)
            readWord = devIndWord;
        else if (hitCmd)
            readWord = cmdWord;
        else if (hitQual)
            readWord = qualWord;
    end

    assign excCode = !hitAny                  ? `MVE_EXC_ILL_ADDR :
                     isWrite && !hitWritable  ? `MVE_EXC_ILL_VALUE :
                     timeCommit && timeBad    ? `MVE_EXC_SERVER_FAIL :
                                                `MVE_EXC_NONE;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            busResp <= '0;
        else
        begin
            busResp.valid <= busReq.valid;
            busResp.rdata <= (busReq.valid && !isWrite) ? readWord
                                                        : 16'h0000;
            busResp.exc   <= busReq.valid ? excCode : `MVE_EXC_NONE;
        end
    end

endmodule : mve_value_encoder

// ### design/mve_regs.svh
/*
 * Register offsets, field codes, limits and timing counts of the
 * holding-register value encoder.
 * Assumes a 20 MHz system clock and holding-register numbers given
 * as plain decimal offsets, for example register 0065 at 16'h0041.
 */
`ifndef MVE_REGS_SVH
`define MVE_REGS_SVH

// ----------------------------------------------------------------
// holding register offsets
// ----------------------------------------------------------------
`define MVE_REG_TIME_MS      16'h0041
`define MVE_REG_TIME_HM      16'h0042
`define MVE_REG_TIME_MD      16'h0043
`define MVE_REG_TIME_SY      16'h0044
`define MVE_REG_DEV_IND      16'h0065
`define MVE_REG_CMD_IND      16'h008d
`define MVE_REG_MEAS_BASE    16'h00c9
`define MVE_REG_CNT_BASE     16'h0321
`define MVE_REG_CNT_QUAL     16'h0349
`define MVE_REG_PULSE_FACTOR 16'h034b

// ----------------------------------------------------------------
// measured value status codes
// ----------------------------------------------------------------
`define MVE_F_OVERFLOW       32'h7f800000
`define MVE_F_INVALID        32'h7f800001
`define MVE_F_NOTCALC        32'h7f800002

// ----------------------------------------------------------------
// date/time fields
// ----------------------------------------------------------------
`define MVE_TS_DST           8'h10
`define MVE_TS_FAIL          8'h20
`define MVE_MS_MAX           16'hea5f
`define MVE_HOUR_MAX         8'h17
`define MVE_MIN_MAX          8'h3b
`define MVE_MONTH_MAX        8'h0c
`define MVE_DAY_MAX          8'h1f

// ----------------------------------------------------------------
// magnitude thresholds, magnitudes scaled so rated reads 1000
// ----------------------------------------------------------------
`define MVE_RATED_MAG        16'h03e8
`define MVE_VOLT_OVF         (`MVE_RATED_MAG * 16'h000c / 16'h000a)
`define MVE_CURR_OVF         (`MVE_RATED_MAG * 16'h0002)
`define MVE_VOLT_LOW         (`MVE_RATED_MAG * 16'h000f / 16'h0064)

// ----------------------------------------------------------------
// counters
// ----------------------------------------------------------------
`define MVE_CNT_MAX          32'sh7fffffff
`define MVE_RATED_POWER      40'sh0000010000
`define MVE_CMD_CNT_RESET    3'h7

// ----------------------------------------------------------------
// exception codes
// ----------------------------------------------------------------
`define MVE_EXC_NONE         8'h00
`define MVE_EXC_ILL_ADDR     8'h02
`define MVE_EXC_ILL_VALUE    8'h03
`define MVE_EXC_SERVER_FAIL  8'h04

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MVE_CLK_HZ           64'd20000000
`define MVE_MINUTE_S         64'd60
`define MVE_MINUTE_CYCLES    (`MVE_MINUTE_S * `MVE_CLK_HZ)
`define MVE_HOUR_S           64'd3600
`define MVE_PULSES_PER_HOUR  64'd60000
`define MVE_PULSE_CYCLES \
    (`MVE_HOUR_S * `MVE_CLK_HZ / `MVE_PULSES_PER_HOUR)

`endif

// ### design/mve_pkg.sv
/*
 * Types shared by the value encoder and its energy counter.
 * Assumes the request side presents one holding-register access at a
 * time as a single-cycle valid.
 */
package mve_pkg;

    // one holding-register access
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mve_req_t;

    // answer to one access, exc zero on success
    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
        logic [7:0]  exc;
    } mve_resp_t;

    // local date and time
    typedef struct packed {
        logic [15:0] ms;
        logic [7:0]  hour;
        logic [7:0]  minute;
        logic [7:0]  month;
        logic [7:0]  day;
        logic [7:0]  year;
        logic        dst;
        logic        fail;
    } mve_time_t;

endpackage : mve_pkg

// ### design/mve_energy_counter.sv
/*
 * One signed energy counter: integrates power into pulses and counts
 * them, flagging a wrap past the 31-bit magnitude.
 * Assumes power comes from logic on sys_clk, scaled so that rated
 * voltage times rated current reads 65536.
 */
`timescale 1ns/1ns
`include "mve_regs.svh"

module mve_energy_counter #(
    parameter longint unsigned PULSE_CYCLES = `MVE_PULSE_CYCLES
) (
    input  wire logic               sys_clk, // system clock
    input  wire logic               rstn,    // sync reset, low active
    input  wire logic signed [17:0] power,   // signed power, rated 65536
    input  wire logic               clear,   // counter reset command
    output logic signed [31:0]      count,   // signed pulse count
    output logic                    wrap     // sticky wrap flag
);
    import mve_pkg::*;

    // energy of one pulse in power-cycles
    localparam logic signed [39:0] THRESH =
        40'(PULSE_CYCLES) * `MVE_RATED_POWER;

    logic signed [39:0] acc;
    logic signed [39:0] sumAcc;
    logic               pulseUp;
    logic               pulseDown;
    logic signed [39:0] next_acc;
    logic               atPosMax;
    logic               atNegMax;
    logic               wrapEvent;
    logic signed [31:0] next_count;

    // ----------------------------------------------------------------
    // pulse generation: rated power gives a fixed pulse rate
    // ----------------------------------------------------------------
    assign sumAcc    = acc + 40'(power);
    assign pulseUp   = sumAcc >= THRESH;
    assign pulseDown = sumAcc <= -THRESH;
    assign next_acc  = pulseUp   ? sumAcc - THRESH :
                       pulseDown ? sumAcc + THRESH : sumAcc;

    // ----------------------------------------------------------------
    // count limited to +/-2147483647, beyond that it wraps
    // ----------------------------------------------------------------
    assign atPosMax   = count == `MVE_CNT_MAX;
    assign atNegMax   = count == -`MVE_CNT_MAX;
    assign wrapEvent  = (pulseUp & atPosMax) | (pulseDown & atNegMax);
    assign next_count = wrapEvent ? 32'sh0 :
                        pulseUp   ? count + 32'sh1 :
                        pulseDown ? count - 32'sh1 : count;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || clear)
        begin
            acc   <= 40'sh0;
            count <= 32'sh0;
        end
        else
        begin
            acc   <= next_acc;
            count <= next_count;
        end
    end

    // a wrap in the cycle of a clear still shows: set beats clear
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            wrap <= 1'b0;
        else
            wrap <= (wrap & ~clear) | wrapEvent;
    end

endmodule : mve_energy_counter

// ### bench/mve_value_encoder_asserts.sv
/* checker on the register port and command outputs of the encoder
   assumes it is bound to the encoder from the bench top */
`timescale 1ns/1ns
module mve_value_encoder_asserts (
    input wire logic               sys_clk,    // clock
    input wire logic               rstn,       // sync reset
    input wire mve_pkg::mve_req_t  busReq,     // access
    input wire mve_pkg::mve_resp_t busResp,    // answer
    input wire logic               timeSetStb, // time load
    input wire logic [7:0]         cmdState,   // commanded
    input wire logic [7:0]         cmdOnPulse, // ON done
    input wire logic [7:0]         cmdOffPulse // OFF done
);
    import mve_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire rdq = busReq.valid & ~busReq.write;
    wire wrq = busReq.valid & busReq.write;
    sequence cmd_wr(d);
        wrq && busReq.addr == 16'h008d && busReq.wdata == d;
    endsequence
    ans_next_a: assert property (busReq.valid |=> busResp.valid)
        else $error("no answer");
    ro_write_a: assert property (wrq && busReq.addr == 16'h0065
        |=> busResp.exc == 8'h03) else $error("ro write taken");
    cmd_on_a: assert property (cmd_wr(16'h8000)
        |=> cmdOnPulse == 8'h80 && cmdState[7]) else $error("on lost");
    cmd_off_a: assert property (cmd_wr(16'h4003) |=> cmdOnPulse == 0
        && cmdOffPulse == 8'h80 && !cmdState[7]) else $error("off lost");
    cmd_idle_a: assert property (!wrq |=> !cmdOnPulse && !cmdOffPulse)
        else $error("stray pulse");
    dev_trust_a: assert property (rdq && busReq.addr == 16'h0065
        |=> !busResp.rdata[1]) else $error("ready trust set");
    qual_hi_a: assert property (rdq && busReq.addr == 16'h0349
        |=> busResp.rdata[15:8] == 8'h00) else $error("unused pairs");
    time_load_a: assert property (timeSetStb |-> $past(wrq))
        else $error("load without write");
endmodule : mve_value_encoder_asserts

// ### bench/mve_client.sv
/* client model: one holding-register access at a time
   assumes the answer stands in the cycle after the taking edge */
`timescale 1ns/1ns
module mve_client (
    input  wire logic               sys_clk, // clock
    input  wire mve_pkg::mve_resp_t rsp,     // answer
    output mve_pkg::mve_req_t       req      // request
);
    import mve_pkg::*;
    initial req = '0;
    // request held over one taking edge, answer read once settled
    task automatic xfer(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q, output logic [7:0] e);
        req = '{1'b1, w, a, d};
        @(posedge sys_clk);
        #1 q = rsp.rdata;
        e = rsp.exc;
    endtask : xfer
    // valid stays up between back-to-back calls; idle releases the bus
    task automatic idle;
        req = '{1'b0, ~req.write, ~req.addr, ~req.wdata};
    endtask : idle
endmodule : mve_client

// ### bench/mve_value_encoder_tb_top.sv
/* bench for the value encoder: client model, checker, scenarios
   assumes short minute and pulse counts so the run stays brief */
`timescale 1ns/1ns
`define CHK(g, x) begin numChecks++; if ((g) !== (x)) begin badCount++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module mve_value_encoder_tb_top;
    import mve_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rstn = 1'b0;
    mve_req_t         busReq;
    mve_resp_t        busResp;
    logic [3:0][31:0] measRaw = {32'hc2c80000, 96'h0};
    logic [3:0]       measNotCalc = 4'h0, measInvalid = 4'h0;
    logic [15:0]      voltMag = 16'h03e8, currMag = 16'h03e8, q;
    logic [31:0]      pulseFactor = 32'h3dcccccd;
    mve_time_t        rtcNow = {16'hea5f, 16'h0506, 24'h0c1f7b, 2'b11};
    mve_time_t        timeSet;
    logic             timeSetStb, devReady = 1'b1;
    logic [7:0]       indValue = 8'hf2, indTrust = 8'h11, indFreqDep = 8'h20;
    logic [3:0][17:0] cntPower = {36'h0, 18'h30000, 18'h10000};
    logic [7:0]       cmdState, cmdOnPulse, cmdOffPulse, e;
    int               badCount = 0, numChecks = 0;
    always #25 sys_clk = ~sys_clk;
    mve_client cli (.sys_clk, .rsp(busResp), .req(busReq));
    mve_value_encoder #(.MINUTE_CYCLES(50), .PULSE_CYCLES(4)) dut (
        .sys_clk, .rstn, .busReq, .busResp, .measRaw, .measNotCalc,
        .measInvalid, .voltMag, .currMag, .pulseFactor, .rtcNow, .timeSet,
        .timeSetStb, .devReady, .indValue, .indTrust, .indFreqDep,
        .cntPower, .cmdState, .cmdOnPulse, .cmdOffPulse);
    task automatic rd(input logic [15:0] a, x);
        cli.xfer(1'b0, a, 16'h0000, q, e);
        `CHK(q, x)
    endtask : rd
    task automatic wr(input logic [15:0] a, d, input logic [7:0] x);
        cli.xfer(1'b1, a, d, q, e);
        `CHK(e, x)
    endtask : wr
    task automatic t_cnt;
        rd(16'h0349, 16'h0055);
        cli.idle();
        repeat (50) @(posedge sys_clk);
        #1 rd(16'h0349, 16'h0000);
        rd(16'h0323, 16'hffff);
        wr(16'h008d, 16'h8000, 8'h00);
        cli.idle();
        @(posedge sys_clk);
        #1 rd(16'h0349, 16'h0055);
        $display("counters done");
    endtask : t_cnt
    task automatic t_meas;
        rd(16'h00cf, 16'hc2c8);
        rd(16'h00d0, 16'h0000);
        measNotCalc = 4'h2;
        measInvalid = 4'h6;
        rd(16'h00cc, 16'h0002);
        rd(16'h00ce, 16'h0001);
        measInvalid = 4'h0;
        currMag = 16'h07d1;
        rd(16'h00cd, 16'h7f80);
        voltMag = 16'h0095;
        rd(16'h00ca, 16'h0001);
        voltMag = 16'h03e8;
        $display("measured done");
    endtask : t_meas
    task automatic t_time;
        rd(16'h0044, 16'h307b);
        rd(16'h0042, 16'h0506);
        rd(16'h0041, 16'hea5f);
        wr(16'h0043, 16'h0c1f, 8'h00);
        wr(16'h0044, 16'h1064, 8'h00);
        wr(16'h0041, 16'hea5f, 8'h00);
        `CHK(timeSetStb, 1'b0)
        wr(16'h0042, 16'h173b, 8'h00);
        `CHK(timeSetStb, 1'b1)
        `CHK(timeSet, {16'hea5f, 16'h173b, 24'h0c1f64, 2'b10})
        wr(16'h0043, 16'h0d01, 8'h00);
        wr(16'h0044, 16'h1064, 8'h00);
        wr(16'h0041, 16'h0000, 8'h00);
        wr(16'h0042, 16'h0000, 8'h04);
        $display("time done");
    endtask : t_time
    task automatic t_ind;
        rd(16'h0065, 16'h5705);
        voltMag = 16'h0095;
        rd(16'h0065, 16'h5f05);
        voltMag = 16'h03e8;
        wr(16'h0065, 16'h0000, 8'h03);
        rd(16'h0000, 16'h0000);
        `CHK(e, 8'h02)
        rd(16'h034b, 16'h3dcc);
        rd(16'h034c, 16'hcccd);
        $display("indications done");
    endtask : t_ind
    task automatic t_cmd;
        wr(16'h008d, 16'h0002, 8'h00);
        `CHK(cmdOnPulse, 8'h01)
        rd(16'h008d, 16'h4001);
        wr(16'h008d, 16'h4003, 8'h00);
        rd(16'h008d, 16'h0001);
        $display("commands done");
    endtask : t_cmd
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tallyAndFinish
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1 rstn = 1'b1;
        @(posedge sys_clk);
        #1 t_cnt();
        t_meas();
        t_time();
        t_ind();
        t_cmd();
        tallyAndFinish();
    end
    // scenarios need some 95 cycles; 10000 leaves ample margin
    initial
    begin
        #500000 badCount++;
        tallyAndFinish();
    end
endmodule : mve_value_encoder_tb_top
bind mve_value_encoder mve_value_encoder_asserts chk (.sys_clk, .rstn,
    .busReq, .busResp, .timeSetStb, .cmdState, .cmdOnPulse, .cmdOffPulse);
